// ### pkg/fcd_pkg.sv
// Constants, types and command codes for the flash command decoder.
// Assumes bus writes arrive already synchronised to sys_clk as one-cycle strobes.
// Function
// [R1] Accept single-cycle and setup/confirm two-cycle commands
// [R2] Reads between setup and confirm keep setup
// [R3] Stray write mid-command aborts, sets bits 7,5,4
// [R4] 0060h/0003h loads read config from address
// [R5] 0060h/0004h loads extended config from address
// [R6] 00C0h arms one-time area write next cycle
// [R7] 0050h clears error bits, keeps device bits
// [R8] 00FFh sets addressed partition to array read
// [R9] 0070h sets addressed partition to status read
// [R10] 0090h sets addressed partition to identifier read
// [R11] 0098h sets addressed partition to query read
// [R12] 0041h arms word program, then status read
// [R13] 00E9h/00D0h buffered program, then status read
// [R14] 0080h/00D0h factory program, then status read
// [R15] 0020h/00D0h erases block at confirm, status read
// [R16] 0060h then 0001h lock, 00D0h unlock, 002Fh down
// [R17] 00B0h suspends; bit 6 erase, bit 2 program
// [R18] 00D0h resumes; nested program resumes first
// [R19] 00BCh/00D0h blank check, then status read
// [R20] Capture on first rising write or enable edge
// [R21] Clear status also selects status read there
// [R22] Bits 5 and 4 mean sequence error; sticky
// [R23] Each partition holds mode until changed or reset
// [R24] Bad confirm code is a sequence error
`default_nettype none
package fcd_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int PART_W = 3;
  localparam int PART_LSB = 21;

  localparam logic [15:0] CMD_RCR_CONF = 16'h0003;
  localparam logic [15:0] CMD_ECR_CONF = 16'h0004;
  localparam logic [15:0] CMD_LOCK_CONF = 16'h0001;
  localparam logic [15:0] CMD_DOWN_CONF = 16'h002F;
  localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
  localparam logic [15:0] CMD_CFG_SETUP = 16'h0060;
  localparam logic [15:0] CMD_OTP = 16'h00C0;
  localparam logic [15:0] CMD_CLR_STAT = 16'h0050;
  localparam logic [15:0] CMD_RD_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_RD_STAT = 16'h0070;
  localparam logic [15:0] CMD_RD_ID = 16'h0090;
  localparam logic [15:0] CMD_RD_QRY = 16'h0098;
  localparam logic [15:0] CMD_WORD_PGM = 16'h0041;
  localparam logic [15:0] CMD_BUF_PGM = 16'h00E9;
  localparam logic [15:0] CMD_FACT_PGM = 16'h0080;
  localparam logic [15:0] CMD_ERASE = 16'h0020;
  localparam logic [15:0] CMD_SUSPEND = 16'h00B0;
  localparam logic [15:0] CMD_BLANK = 16'h00BC;

  // Status word bit positions, error mask and reset values
  localparam int ST_READY = 7;
  localparam int ST_ERS_SUSP = 6;
  localparam int ST_ERS_ERR = 5;
  localparam int ST_PGM_ERR = 4;
  localparam int ST_VPP_ERR = 3;
  localparam int ST_PGM_SUSP = 2;
  localparam int ST_LOCK_ERR = 1;
  localparam logic [15:0] ST_ERR_MASK = 16'h033A;
  localparam logic [15:0] ST_RESET = 16'h0080;
  localparam logic [15:0] RCR_RESET = 16'hBFCF;
  localparam logic [15:0] ECR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    FCD_RD_ARRAY = 2'b00,
    FCD_RD_STAT = 2'b01,
    FCD_RD_ID = 2'b10,
    FCD_RD_QRY = 2'b11
  } fcd_mode_e;

  typedef enum logic [2:0] {
    FCD_IDLE = 3'b000,
    FCD_CFG = 3'b001,
    FCD_ERS = 3'b010,
    FCD_BUF = 3'b011,
    FCD_FACT = 3'b100,
    FCD_BLANK = 3'b101,
    FCD_WORD = 3'b110,
    FCD_OTP = 3'b111
  } fcd_state_e;

  typedef enum logic [3:0] {
    FCD_OP_NONE = 4'h0,
    FCD_OP_WORD = 4'h1,
    FCD_OP_BUF = 4'h2,
    FCD_OP_FACT = 4'h3,
    FCD_OP_ERASE = 4'h4,
    FCD_OP_BLANK = 4'h5,
    FCD_OP_LOCK = 4'h6,
    FCD_OP_UNLOCK = 4'h7,
    FCD_OP_DOWN = 4'h8,
    FCD_OP_OTP = 4'h9,
    FCD_OP_SUSP = 4'hA,
    FCD_OP_RES_PGM = 4'hB,
    FCD_OP_RES_ERS = 4'hC
  } fcd_op_e;

  // One launch toward the array engine
  typedef struct packed {
    logic valid;
    fcd_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcd_launch_s;

endpackage : fcd_pkg
`default_nettype wire

// ### design/fcd_decoder.sv
// Command decoder of a partitioned flash: interprets bus writes, keeps read
// modes, configuration words and the status word, and launches operations.
// Assumes write pins are synchronous to sys_clk; the array engine reports
// busy, program or erase activity and error events through the engine inputs.
`timescale 1ns/1ps
`default_nettype none
module fcd_decoder #(
  parameter int PARTS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic address_valid_n,
  input wire logic [fcd_pkg::ADDR_W-1:0] addr,
  input wire logic [fcd_pkg::DATA_W-1:0] wdata,
  // Array engine side
  input wire logic eng_busy,
  input wire logic eng_pgm_active,
  input wire logic eng_ers_active,
  input wire logic [fcd_pkg::DATA_W-1:0] eng_err,
  // Outputs
  output var fcd_pkg::fcd_launch_s launch,
  output logic [fcd_pkg::DATA_W-1:0] status_word,
  output logic [fcd_pkg::DATA_W-1:0] rcr,
  output logic [fcd_pkg::DATA_W-1:0] ecr,
  output logic [2*PARTS-1:0] part_mode
);

  logic wr_prev_r;
  logic wr_prev_nxt;
  logic wr_evt;
  logic [fcd_pkg::ADDR_W-1:0] cap_addr_r;
  logic [fcd_pkg::DATA_W-1:0] cap_data_r;
  logic [fcd_pkg::ADDR_W-1:0] cap_addr_nxt;
  logic [fcd_pkg::DATA_W-1:0] cap_data_nxt;
  fcd_pkg::fcd_state_e state_r;
  fcd_pkg::fcd_state_e state_nxt;
  fcd_pkg::fcd_launch_s launch_r;
  fcd_pkg::fcd_launch_s launch_nxt;
  logic [fcd_pkg::DATA_W-1:0] stat_r;
  logic [fcd_pkg::DATA_W-1:0] stat_nxt;
  logic [fcd_pkg::DATA_W-1:0] rcr_r;
  logic [fcd_pkg::DATA_W-1:0] rcr_nxt;
  logic [fcd_pkg::DATA_W-1:0] ecr_r;
  logic [fcd_pkg::DATA_W-1:0] ecr_nxt;
  logic ers_susp_r;
  logic ers_susp_nxt;
  logic pgm_susp_r;
  logic pgm_susp_nxt;
  logic seq_err;
  logic clr_err;
  logic mode_wr;
  fcd_pkg::fcd_mode_e mode_val;
  logic [fcd_pkg::PART_W-1:0] tgt_part;
  logic [2*PARTS-1:0] mode_r;
  logic [2*PARTS-1:0] mode_nxt;
  logic wr_low;
  logic cap_edge;

  // Write window is CE and WE low with OE high; its end is the capture edge
  assign wr_low = !ce_n && !we_n && oe_n;
  assign cap_edge = wr_prev_r && !wr_low;  // R20

  // Capture of address and data while the write window is open
  always_comb begin
    wr_prev_nxt = wr_low;
    cap_addr_nxt = cap_addr_r;
    cap_data_nxt = cap_data_r;
    if (wr_low) begin
      cap_addr_nxt = addr;  // R20
      cap_data_nxt = wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_prev_r <= 1'b0;
      cap_addr_r <= '0;
      cap_data_r <= '0;
    end else begin
      wr_prev_r <= wr_prev_nxt;
      cap_addr_r <= cap_addr_nxt;
      cap_data_r <= cap_data_nxt;
    end
  end

  assign wr_evt = cap_edge;
  assign tgt_part = cap_addr_r[fcd_pkg::PART_LSB +: fcd_pkg::PART_W];

  // Command interpreter: setup, confirm and data cycles
  always_comb begin
    state_nxt = state_r;
    launch_nxt = '0;
    launch_nxt.addr = cap_addr_r;
    launch_nxt.data = cap_data_r;
    rcr_nxt = rcr_r;
    ecr_nxt = ecr_r;
    ers_susp_nxt = ers_susp_r;
    pgm_susp_nxt = pgm_susp_r;
    seq_err = 1'b0;
    clr_err = 1'b0;
    mode_wr = 1'b0;
    mode_val = fcd_pkg::FCD_RD_ARRAY;
    // Reads never reach here, so a pending setup survives them
    if (wr_evt) begin  // R2
      case (state_r)
        fcd_pkg::FCD_IDLE: begin  // R1
          case (cap_data_r)
            fcd_pkg::CMD_CFG_SETUP: state_nxt = fcd_pkg::FCD_CFG;
            fcd_pkg::CMD_ERASE: state_nxt = fcd_pkg::FCD_ERS;
            fcd_pkg::CMD_BUF_PGM: state_nxt = fcd_pkg::FCD_BUF;
            fcd_pkg::CMD_FACT_PGM: state_nxt = fcd_pkg::FCD_FACT;
            fcd_pkg::CMD_BLANK: state_nxt = fcd_pkg::FCD_BLANK;
            fcd_pkg::CMD_WORD_PGM: state_nxt = fcd_pkg::FCD_WORD;  // R12
            fcd_pkg::CMD_OTP: state_nxt = fcd_pkg::FCD_OTP;  // R6
            fcd_pkg::CMD_CLR_STAT: begin
              clr_err = 1'b1;  // R7
              mode_wr = 1'b1;  // R21
              mode_val = fcd_pkg::FCD_RD_STAT;
            end
            fcd_pkg::CMD_RD_ARRAY: begin
              mode_wr = 1'b1;  // R8
              mode_val = fcd_pkg::FCD_RD_ARRAY;
            end
            fcd_pkg::CMD_RD_STAT: begin
              mode_wr = 1'b1;  // R9
              mode_val = fcd_pkg::FCD_RD_STAT;
            end
            fcd_pkg::CMD_RD_ID: begin
              mode_wr = 1'b1;  // R10
              mode_val = fcd_pkg::FCD_RD_ID;
            end
            fcd_pkg::CMD_RD_QRY: begin
              mode_wr = 1'b1;  // R11
              mode_val = fcd_pkg::FCD_RD_QRY;
            end
            fcd_pkg::CMD_SUSPEND: begin
              if (eng_busy && (eng_pgm_active || eng_ers_active)) begin  // R17
                launch_nxt.valid = 1'b1;
                launch_nxt.op = fcd_pkg::FCD_OP_SUSP;
                if (eng_pgm_active) begin
                  pgm_susp_nxt = 1'b1;
                end else begin
                  ers_susp_nxt = 1'b1;
                end
              end
            end
            fcd_pkg::CMD_CONFIRM: begin
              // Nested program suspend resumes before the erase
              if (pgm_susp_r) begin  // R18
                pgm_susp_nxt = 1'b0;
                launch_nxt.valid = 1'b1;
                launch_nxt.op = fcd_pkg::FCD_OP_RES_PGM;
              end else if (ers_susp_r) begin
                ers_susp_nxt = 1'b0;
                launch_nxt.valid = 1'b1;
                launch_nxt.op = fcd_pkg::FCD_OP_RES_ERS;
              end
            end
            default: ;
          endcase
        end
        fcd_pkg::FCD_CFG: begin
          state_nxt = fcd_pkg::FCD_IDLE;
          launch_nxt.valid = 1'b1;
          case (cap_data_r)
            fcd_pkg::CMD_RCR_CONF: begin
              launch_nxt.valid = 1'b0;
              rcr_nxt = cap_addr_r[fcd_pkg::DATA_W-1:0];  // R4
            end
            fcd_pkg::CMD_ECR_CONF: begin
              launch_nxt.valid = 1'b0;
              ecr_nxt = cap_addr_r[fcd_pkg::DATA_W-1:0];  // R5
            end
            fcd_pkg::CMD_LOCK_CONF: launch_nxt.op = fcd_pkg::FCD_OP_LOCK;  // R16
            fcd_pkg::CMD_CONFIRM: launch_nxt.op = fcd_pkg::FCD_OP_UNLOCK;  // R16
            fcd_pkg::CMD_DOWN_CONF: launch_nxt.op = fcd_pkg::FCD_OP_DOWN;  // R16
            default: begin
              launch_nxt.valid = 1'b0;
              seq_err = 1'b1;  // R3 R24
            end
          endcase
        end
        fcd_pkg::FCD_ERS, fcd_pkg::FCD_BUF, fcd_pkg::FCD_FACT, fcd_pkg::FCD_BLANK: begin
          state_nxt = fcd_pkg::FCD_IDLE;
          if (cap_data_r == fcd_pkg::CMD_CONFIRM) begin
            launch_nxt.valid = 1'b1;  // R15 R13 R14 R19
            mode_wr = 1'b1;
            mode_val = fcd_pkg::FCD_RD_STAT;
            case (state_r)
              fcd_pkg::FCD_ERS: launch_nxt.op = fcd_pkg::FCD_OP_ERASE;
              fcd_pkg::FCD_BUF: launch_nxt.op = fcd_pkg::FCD_OP_BUF;
              fcd_pkg::FCD_FACT: launch_nxt.op = fcd_pkg::FCD_OP_FACT;
              default: launch_nxt.op = fcd_pkg::FCD_OP_BLANK;
            endcase
          end else begin
            seq_err = 1'b1;  // R3 R24
          end
        end
        fcd_pkg::FCD_WORD: begin
          state_nxt = fcd_pkg::FCD_IDLE;
          launch_nxt.valid = 1'b1;  // R12
          launch_nxt.op = fcd_pkg::FCD_OP_WORD;
          mode_wr = 1'b1;
          mode_val = fcd_pkg::FCD_RD_STAT;
        end
        fcd_pkg::FCD_OTP: begin
          state_nxt = fcd_pkg::FCD_IDLE;
          launch_nxt.valid = 1'b1;  // R6
          launch_nxt.op = fcd_pkg::FCD_OP_OTP;
        end
        default: state_nxt = fcd_pkg::FCD_IDLE;
      endcase
    end
  end

  // Status word: ready follows engine busy or a sequence error, suspend bits the suspend flags, error bits are sticky
  always_comb begin
    stat_nxt = stat_r | (eng_err & fcd_pkg::ST_ERR_MASK);
    if (clr_err) begin
      // An engine error arriving with the clear still lands: set wins
      stat_nxt = (stat_r & ~fcd_pkg::ST_ERR_MASK) | (eng_err & fcd_pkg::ST_ERR_MASK);  // R7 R22
    end
    if (seq_err) begin
      stat_nxt[fcd_pkg::ST_ERS_ERR] = 1'b1;  // R3 R22
      stat_nxt[fcd_pkg::ST_PGM_ERR] = 1'b1;
    end
    stat_nxt[fcd_pkg::ST_READY] = !eng_busy || seq_err;  // R3
    stat_nxt[fcd_pkg::ST_ERS_SUSP] = ers_susp_nxt;  // R17
    stat_nxt[fcd_pkg::ST_PGM_SUSP] = pgm_susp_nxt;  // R17
  end

  // Per-partition read mode, one entry per partition
  genvar gp;
  generate
    for (gp = 0; gp < PARTS; gp++) begin : g_part
      always_comb begin
        mode_nxt[2*gp +: 2] = mode_r[2*gp +: 2];
        if (mode_wr && (tgt_part == fcd_pkg::PART_W'(gp))) begin
          mode_nxt[2*gp +: 2] = mode_val;  // R23
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= fcd_pkg::FCD_IDLE;
      launch_r <= '0;
      stat_r <= fcd_pkg::ST_RESET;
      rcr_r <= fcd_pkg::RCR_RESET;
      ecr_r <= fcd_pkg::ECR_RESET;
      ers_susp_r <= 1'b0;
      pgm_susp_r <= 1'b0;
      mode_r <= '0;  // R23
    end else begin
      state_r <= state_nxt;
      launch_r <= launch_nxt;
      stat_r <= stat_nxt;
      rcr_r <= rcr_nxt;
      ecr_r <= ecr_nxt;
      ers_susp_r <= ers_susp_nxt;
      pgm_susp_r <= pgm_susp_nxt;
      mode_r <= mode_nxt;
    end
  end

  assign launch = launch_r;
  assign status_word = stat_r;
  assign rcr = rcr_r;
  assign ecr = ecr_r;
  assign part_mode = mode_r;

endmodule : fcd_decoder
`default_nettype wire

// ### sim/fcd_decoder_properties.sv
// Port checker for the flash command decoder.
// Assumes one-cycle write windows and answers one cycle after write end.
`timescale 1ns/1ps
`default_nettype none
module fcd_decoder_properties #(
  parameter int PARTS = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus pins
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic address_valid_n,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  // Engine side
  input wire logic eng_busy,
  input wire logic eng_pgm_active,
  input wire logic eng_ers_active,
  input wire logic [15:0] eng_err,
  // Outputs
  input wire fcd_pkg::fcd_launch_s launch,
  input wire logic [15:0] status_word,
  input wire logic [15:0] rcr,
  input wire logic [15:0] ecr,
  input wire logic [2*PARTS-1:0] part_mode
);
  logic win, win_q, pend_r, wend, idle_w, cf_w, bad;
  logic [15:0] d_r, su_r;
  logic [23:0] a_r;
  logic [1:0] pm;
  // Write end, addressed mode and confirm legality
  assign win = !ce_n && !we_n && oe_n;
  assign wend = win_q && !win;
  assign idle_w = wend && !pend_r;
  assign cf_w = wend && pend_r;
  assign pm = part_mode[2*a_r[23:21] +: 2];
  assign bad = cf_w && (su_r == 16'h0060 ? !(d_r inside {16'h0003, 16'h0004, 16'h0001,
    16'h00D0, 16'h002F}) : su_r inside {16'h00E9, 16'h0080, 16'h0020, 16'h00BC} &&
    d_r != 16'h00D0);
  // Last written word and pending setup
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      win_q <= 1'b0;
      pend_r <= 1'b0;
      d_r <= 16'h0000;
      su_r <= 16'h0000;
      a_r <= 24'h00_0000;
    end else begin
      win_q <= win;
      if (win) begin
        a_r <= addr;
        d_r <= wdata;
      end
      if (wend) begin
        pend_r <= !pend_r && (d_r inside {16'h0060, 16'h00E9, 16'h0080, 16'h0020,
          16'h00BC, 16'h0041, 16'h00C0});
        su_r <= d_r;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_mode_select: assert property (idle_w && d_r inside {16'h00FF, 16'h0070,
    16'h0090, 16'h0098} |=> pm == (d_r == 16'h00FF ? 2'd0 : d_r == 16'h0070 ? 2'd1 :
    d_r == 16'h0090 ? 2'd2 : 2'd3)) else $error("read mode not selected");
  chk_clear_errors: assert property (idle_w && d_r == 16'h0050
    |=> (status_word & 16'h033A) == ($past(eng_err) & 16'h033A) && pm == 2'd1)
    else $error("clear failed");
  chk_seq_abort: assert property (bad |=> status_word[7] && status_word[5] &&
    status_word[4] && !launch.valid) else $error("sequence error not flagged");
  chk_rcr_load: assert property (cf_w && su_r == 16'h0060 && d_r == 16'h0003
    |=> rcr == a_r[15:0]) else $error("read config not loaded");
  chk_ecr_load: assert property (cf_w && su_r == 16'h0060 && d_r == 16'h0004
    |=> ecr == a_r[15:0]) else $error("extended config not loaded");
  chk_erase_start: assert property (cf_w && su_r == 16'h0020 && d_r == 16'h00D0
    |=> launch.valid && launch.op == fcd_pkg::FCD_OP_ERASE && pm == 2'd1)
    else $error("erase not launched");
  chk_prog_status: assert property (cf_w && d_r == 16'h00D0 &&
    su_r inside {16'h00E9, 16'h0080, 16'h00BC} |=> launch.valid && pm == 2'd1)
    else $error("program not launched");
  chk_data_write: assert property (cf_w && su_r inside {16'h0041, 16'h00C0}
    |=> launch.valid && launch.data == d_r && launch.addr == a_r) else $error("bad data");
  chk_err_sticky: assert property ($fell(status_word[5]) || $fell(status_word[4])
    |-> $past(idle_w && d_r == 16'h0050)) else $error("error bit lost");
  chk_mode_hold: assert property (!$stable(part_mode) |-> $past(wend))
    else $error("mode changed without write");
  cover property (bad);
  cover property (launch.valid && launch.op == fcd_pkg::FCD_OP_ERASE);
  cover property (idle_w && d_r == 16'h0050);
endmodule : fcd_decoder_properties
bind fcd_decoder fcd_decoder_properties #(.PARTS(PARTS)) chk_i (.sys_clk(sys_clk),
  .rst(rst), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .address_valid_n(address_valid_n),
  .addr(addr), .wdata(wdata), .eng_busy(eng_busy), .eng_pgm_active(eng_pgm_active),
  .eng_ers_active(eng_ers_active), .eng_err(eng_err), .launch(launch),
  .status_word(status_word), .rcr(rcr), .ecr(ecr), .part_mode(part_mode));
`default_nettype wire

// ### sim/fcd_host.sv
// Host bus model issuing write and read cycles.
// Assumes pins synchronous to sys_clk; the bench calls wr and rd.
`timescale 1ns/1ps
`default_nettype none
module fcd_host (
  // Clock
  input wire logic sys_clk,
  // Bus pins
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic address_valid_n,
  output logic [23:0] addr,
  output logic [15:0] wdata
);
  // Idle bus at time zero
  initial begin
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    address_valid_n = 1'b1;
    addr = 24'h00_0000;
    wdata = 16'h0000;
  end
  // Write window one cycle; returns once the decoded result is registered
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    ce_n <= 1'b0;
    we_n <= 1'b0;
    oe_n <= 1'b1;
    address_valid_n <= ~address_valid_n;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    ce_n <= 1'b1;
    we_n <= 1'b1;
    addr <= ~a;
    wdata <= ~d; // Released bus keeps no stale word
    @(posedge sys_clk);
    #1;
  endtask : wr
  // Read cycle between command writes
  task automatic rd(input logic [23:0] a);
    @(posedge sys_clk);
    ce_n <= 1'b0;
    oe_n <= 1'b0;
    addr <= a;
    @(posedge sys_clk);
    ce_n <= 1'b1;
    oe_n <= 1'b1;
    addr <= ~a;
    #1;
  endtask : rd
endmodule : fcd_host
`default_nettype wire

// ### sim/fcd_decoder_bench.sv
// Self-checking bench for the flash command decoder.
// Assumes the host model on the bus pins and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module fcd_decoder_bench;
  localparam int PARTS = 8;
  logic sys_clk, rst, ce_n, we_n, oe_n, address_valid_n;
  logic eng_busy, eng_pgm_active, eng_ers_active;
  logic [23:0] addr;
  logic [15:0] wdata, eng_err, status_word, rcr, ecr;
  logic [2*PARTS-1:0] part_mode;
  fcd_pkg::fcd_launch_s launch;
  int n_errors, samples_checked;
  // Host and device
  fcd_host host (.sys_clk(sys_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .address_valid_n(address_valid_n), .addr(addr), .wdata(wdata));
  fcd_decoder #(.PARTS(PARTS)) uut (.sys_clk(sys_clk), .rst(rst), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .address_valid_n(address_valid_n), .addr(addr),
    .wdata(wdata), .eng_busy(eng_busy), .eng_pgm_active(eng_pgm_active),
    .eng_ers_active(eng_ers_active), .eng_err(eng_err), .launch(launch),
    .status_word(status_word), .rcr(rcr), .ecr(ecr), .part_mode(part_mode));
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [23:0] pa(input int p);
    return {p[2:0], 21'h00_0000};
  endfunction : pa
  function automatic logic [1:0] pm(input int p);
    return part_mode[2*p +: 2];
  endfunction : pm
  task automatic lc(input fcd_pkg::fcd_op_e op);
    check({launch.valid, launch.op}, {1'b1, op});
  endtask : lc
  task automatic t_rst;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check(status_word, 16'h0080);
    check({rcr, ecr}, 32'hBFCF_0000);
    check(part_mode, 0);
    $display("t_rst done");
  endtask : t_rst
  task automatic t_modes;
    logic [15:0] c [4] = '{16'h00FF, 16'h0070, 16'h0090, 16'h0098};
    for (int i = 3; i >= 0; i--) begin
      host.wr(pa(3), c[i]);
      check(pm(3), i);
      check(pm(2), 0);
    end
    $display("t_modes done");
  endtask : t_modes
  task automatic t_erase;
    host.wr(pa(5), 16'h0020);
    host.rd(pa(5));
    host.rd(pa(1));
    check(launch.valid, 0);
    host.wr(pa(5), 16'h00D0);
    lc(fcd_pkg::FCD_OP_ERASE);
    check({launch.addr, pm(5)}, {pa(5), 2'd1});
    $display("t_erase done");
  endtask : t_erase
  task automatic t_abort;
    host.wr(pa(0), 16'h0020);
    host.wr(pa(0), 16'h0070);
    check({status_word[7], status_word[5:4], launch.valid}, 4'b1110);
    host.wr(pa(6), 16'h0050);
    check(status_word & 16'h033A, 0);
    check({pm(6), pm(3)}, 4'b0100);
    host.wr(pa(0), 16'h0060);
    host.wr(pa(0), 16'h0055);
    check(launch.valid, 0);
    @(posedge sys_clk);
    eng_err <= 16'h0008;
    @(posedge sys_clk);
    eng_err <= 16'h0000;
    host.rd(pa(0));
    check(status_word[5:3], 3'b111);
    host.wr(pa(6), 16'h0050);
    check(status_word[5:3], 0);
    $display("t_abort done");
  endtask : t_abort
  task automatic t_cfg;
    host.wr(pa(2), 16'h0060);
    host.wr(24'h40_A5C3, 16'h0003);
    check(rcr, 16'hA5C3);
    host.wr(pa(2), 16'h0060);
    host.rd(pa(2));
    host.wr(24'h40_3C5A, 16'h0004);
    check(ecr, 16'h3C5A);
    for (int i = 0; i < 3; i++) begin
      host.wr(pa(2), 16'h0060);
      host.wr(pa(2), i == 0 ? 16'h0001 : i == 1 ? 16'h00D0 : 16'h002F);
      lc(fcd_pkg::fcd_op_e'(fcd_pkg::FCD_OP_LOCK + i));
    end
    $display("t_cfg done");
  endtask : t_cfg
  task automatic t_prog;
    logic [15:0] s [5] = '{16'h00E9, 16'h0080, 16'h00BC, 16'h0041, 16'h00C0};
    fcd_pkg::fcd_op_e o [5] = '{fcd_pkg::FCD_OP_BUF, fcd_pkg::FCD_OP_FACT,
      fcd_pkg::FCD_OP_BLANK, fcd_pkg::FCD_OP_WORD, fcd_pkg::FCD_OP_OTP};
    for (int i = 0; i < 5; i++) begin
      host.wr(pa(i + 1), s[i]);
      host.rd(pa(i + 1));
      host.wr(pa(i + 1), i < 3 ? 16'h00D0 : 16'hBEEF);
      lc(o[i]);
      if (i < 4) check(pm(i + 1), 1);
      if (i > 2) check(launch.data, 16'hBEEF);
    end
    $display("t_prog done");
  endtask : t_prog
  task automatic t_susp;
    @(posedge sys_clk);
    eng_busy <= 1'b1;
    eng_ers_active <= 1'b1;
    host.wr(pa(4), 16'h00B0);
    lc(fcd_pkg::FCD_OP_SUSP);
    check(status_word[7:6], 2'b01);
    host.wr(pa(4), 16'h0020);
    host.wr(pa(4), 16'h0070);
    check(status_word[7:4], 4'b1111);
    host.wr(pa(4), 16'h0050);
    check(status_word[5:4], 0);
    check(status_word[6], 1);
    @(posedge sys_clk);
    eng_ers_active <= 1'b0;
    eng_pgm_active <= 1'b1;
    host.wr(pa(4), 16'h00B0);
    check(status_word[2], 1);
    @(posedge sys_clk);
    eng_pgm_active <= 1'b0;
    eng_busy <= 1'b0;
    host.wr(pa(0), 16'h00D0);
    lc(fcd_pkg::FCD_OP_RES_PGM);
    host.wr(pa(7), 16'h00D0);
    lc(fcd_pkg::FCD_OP_RES_ERS);
    host.wr(pa(0), 16'h00D0);
    check(launch.valid, 0);
    $display("t_susp done");
  endtask : t_susp
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // Main sequence
  initial begin
    rst = 1'b1;
    {eng_busy, eng_pgm_active, eng_ers_active} = 3'b000;
    eng_err = 16'h0000;
    n_errors = 0;
    samples_checked = 0;
    t_rst();
    t_modes();
    t_erase();
    t_abort();
    t_cfg();
    t_rst();
    t_prog();
    t_susp();
    give_verdict();
  end
  // Hang guard
  initial begin
    repeat (50000) @(posedge sys_clk);
    n_errors++;
    give_verdict();
  end
endmodule : fcd_decoder_bench
`default_nettype wire
